//--- core/dcsw_pkg.sv
// constants, field layouts and carrier types of the disk status-word block
package dcsw_pkg;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS   = 8;
  localparam int WG_SETUP_FM_NS  = 2000;
  localparam int WG_SETUP_MFM_NS = 1000;
  localparam int WG_HOLD_FM_NS   = 2000;
  localparam int WG_HOLD_MFM_NS  = 1000;
  localparam int DRQ_SERVICE_NS  = 13500;
  localparam int CNT_W           = 12;

  // least times round up, the service deadline rounds down
  localparam logic [CNT_W-1:0] WG_SETUP_FM_CYC =
    CNT_W'((WG_SETUP_FM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] WG_SETUP_MFM_CYC =
    CNT_W'((WG_SETUP_MFM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] WG_HOLD_FM_CYC =
    CNT_W'((WG_HOLD_FM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] WG_HOLD_MFM_CYC =
    CNT_W'((WG_HOLD_MFM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] DRQ_SERVICE_CYC =
    CNT_W'(DRQ_SERVICE_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] DRQ_SERVICE_SLOW_CYC =
    CNT_W'(2 * (DRQ_SERVICE_NS / CLK_PERIOD_NS));

  // ==========================================================
  // register select and reset values
  localparam logic [1:0] ADDR_STATUS   = 2'h0;
  localparam logic [1:0] ADDR_DATA     = 2'h3;
  localparam logic [7:0] STATUS_RESET  = 8'h00;
  localparam logic [7:0] STATUS_PRESET = 8'h01;
  localparam logic [8:0] PINS_IDLE     = 9'h0fc;

  // ==========================================================
  // types
  typedef enum logic [3:0] {
    CLS_STEP, CLS_READ, CLS_WRITE, CLS_RDADDR, CLS_RDTRACK,
    CLS_WRTRACK, CLS_FORMAT, CLS_FORCE, CLS_DELAY
  } dcsw_cls_t;

  // status word, bit 7 first
  typedef struct packed {
    logic not_ready;
    logic prot_mark;
    logic rec_type;
    logic seek_rnf;
    logic crc_len;
    logic trk0_lost;
    logic index_drq;
    logic busy;
  } dcsw_status_t;

  typedef struct packed {
    logic verify_fail;
    logic crc_error;
    logic data_mark_missing;
    logic deleted_mark;
    logic record_not_found;
    logic illegal_length;
  } dcsw_evt_t;

  // raw pins, low-active ones marked _b
  typedef struct packed {
    logic       ready;
    logic       write_protect_in_b;
    logic       head_at_home_in_b;
    logic       index_pulse_in_b;
    logic       master_reset_in_b;
    logic       read_strobe_b;
    logic       write_strobe_b;
    logic [1:0] addr;
  } dcsw_pins_t;

endpackage : dcsw_pkg

//--- core/dcsw_status.sv
// status-word register, data-request timing and write-gate sequencing
`timescale 1ns/1ps
`default_nettype none

module dcsw_status (
  input  wire logic                 I_CLK,          // 125 MHz
  input  wire logic                 I_RST_B,        // async, low
  input  wire dcsw_pkg::dcsw_pins_t I_PINS,         // raw drive/bus pins
  input  wire logic                 I_CMD_START,    // command accepted
  input  wire dcsw_pkg::dcsw_cls_t  I_CMD_CLASS,    // class of command
  input  wire logic                 I_CMD_DONE,     // command finished
  input  wire logic                 I_EXT_MODE,     // extended set on
  input  wire dcsw_pkg::dcsw_evt_t  I_EVENT,        // error events
  input  wire logic                 I_BYTE_READY,   // data reg needs host
  input  wire logic                 I_HALF_RATE,    // 4 MHz service deadline
  input  wire logic                 I_WRITE_REQ,    // encoder has data
  input  wire logic                 I_WRITE_PULSE,  // encoder pulse
  input  wire logic                 I_MFM,          // double density
  output logic [7:0]                O_DATA,         // bus data out
  output logic                      O_DATA_OE,      // bus data enable
  output logic                      O_DATA_REQUEST, // request level
  output logic                      O_DATA_REQUEST_OUT, // pin level
  output logic                      O_DATA_REQUEST_OE,  // pin enable
  output logic                      O_WRITE_GATE_OUT,   // write gate
  output logic                      O_WRITE_PULSE_OUT   // write data
);
  import dcsw_pkg::*;

  // ==========================================================
  // pin synchronisers
  dcsw_pins_t s1;
  dcsw_pins_t s2;
  dcsw_pins_t s3;
  dcsw_pins_t pin;
  logic       re_prev;
  logic       we_prev;

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      s1 <= dcsw_pins_t'(PINS_IDLE);
      s2 <= dcsw_pins_t'(PINS_IDLE);
      s3 <= dcsw_pins_t'(PINS_IDLE);
    end else begin
      s1 <= I_PINS;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a bit moves only once the second and third stages agree
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      pin <= dcsw_pins_t'(PINS_IDLE);
    end else begin
      pin <= dcsw_pins_t'((s2 & s3) | (pin & (s2 ^ s3)));
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      re_prev <= 1'b1;
      we_prev <= 1'b1;
    end else begin
      re_prev <= pin.read_strobe_b;
      we_prev <= pin.write_strobe_b;
    end
  end

  logic mr_active;
  logic data_access;
  logic start_new;
  logic force_cmd;

  assign mr_active   = ~pin.master_reset_in_b;
  assign data_access = ((re_prev & ~pin.read_strobe_b) |
                        (we_prev & ~pin.write_strobe_b)) &
                       (pin.addr == ADDR_DATA);
  assign force_cmd   = I_CMD_START & (I_CMD_CLASS == CLS_FORCE);
  assign start_new   = I_CMD_START & (I_CMD_CLASS != CLS_FORCE);

  // set always beats clear, so no event is lost on a preset
  function automatic logic sticky(input logic cur, input logic set,
                                  input logic clr);
    return set | (cur & ~clr);
  endfunction : sticky

  // ==========================================================
  // command class and busy
  dcsw_cls_t cls;
  logic      ext_mode;
  logic      busy;

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      cls      <= CLS_STEP;
      ext_mode <= 1'b0;
    end else if (mr_active) begin
      cls      <= CLS_STEP;
      ext_mode <= 1'b0;
    end else if (start_new) begin
      cls      <= I_CMD_CLASS;
      ext_mode <= I_EXT_MODE;
    end else if (force_cmd && !busy) begin
      // a force while running keeps the running command's layout
      cls      <= CLS_FORCE;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      busy <= 1'b0;
    end else if (mr_active) begin
      busy <= 1'b0;
    end else if (start_new) begin
      busy <= 1'b1;
    end else if (I_CMD_DONE || force_cmd) begin
      busy <= 1'b0;
    end
  end

  // ==========================================================
  // sticky error flags, preset at each command start except a force
  logic flag_clr;
  logic seek_err;
  logic crc_err;
  logic dmark_nf;
  logic rec_type;
  logic rnf;
  logic ill_len;
  logic lost;

  assign flag_clr = start_new | mr_active;

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      seek_err <= 1'b0;
      crc_err  <= 1'b0;
      dmark_nf <= 1'b0;
      rec_type <= 1'b0;
      rnf      <= 1'b0;
      ill_len  <= 1'b0;
    end else begin
      seek_err <= sticky(seek_err, I_EVENT.verify_fail, flag_clr);
      crc_err  <= sticky(crc_err, I_EVENT.crc_error, flag_clr);
      dmark_nf <= sticky(dmark_nf,
                         I_EVENT.data_mark_missing & ext_mode,
                         flag_clr);
      rec_type <= sticky(rec_type, I_EVENT.deleted_mark, flag_clr);
      rnf      <= sticky(rnf, I_EVENT.record_not_found, flag_clr);
      ill_len  <= sticky(ill_len, I_EVENT.illegal_length, flag_clr);
    end
  end

  // ==========================================================
  // data request and service deadline
  logic             data_request_out;
  logic [CNT_W-1:0] svc_cnt;
  logic [CNT_W-1:0] svc_limit;
  logic             svc_expired;
  logic             overrun;

  // the deadline belongs to the host; missing it only flags lost data
  assign svc_limit   = I_HALF_RATE ? DRQ_SERVICE_SLOW_CYC
                                   : DRQ_SERVICE_CYC;
  assign svc_expired = data_request_out & (svc_cnt >= svc_limit);
  assign overrun     = data_request_out & I_BYTE_READY & ~data_access;

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      data_request_out <= 1'b0;
    end else begin
      data_request_out <= sticky(data_request_out, I_BYTE_READY & ~mr_active,
                    data_access | flag_clr);
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      svc_cnt <= '0;
    end else if (!data_request_out || I_BYTE_READY || data_access) begin
      svc_cnt <= '0;
    end else if (svc_cnt < svc_limit) begin
      svc_cnt <= svc_cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      lost <= 1'b0;
    end else begin
      lost <= sticky(lost, svc_expired | overrun, flag_clr);
    end
  end

  // ==========================================================
  // status word assembly
  dcsw_status_t next_status;
  dcsw_status_t command_status;
  logic         wp;
  logic         trk0;
  logic         idx;

  assign wp   = ~pin.write_protect_in_b;
  assign trk0 = ~pin.head_at_home_in_b;
  assign idx  = ~pin.index_pulse_in_b;

  always_comb begin
    next_status           = dcsw_status_t'(STATUS_RESET);
    next_status.not_ready = ~pin.ready | mr_active;
    next_status.busy      = busy;
    case (cls)
      CLS_STEP: begin
        next_status.prot_mark = wp;
        next_status.rec_type  = 1'b1;
        next_status.seek_rnf  = seek_err;
        next_status.crc_len   = crc_err;
        next_status.trk0_lost = trk0;
        next_status.index_drq = idx;
      end
      CLS_READ: begin
        next_status.prot_mark = dmark_nf & ext_mode;
        next_status.rec_type  = rec_type;
        next_status.seek_rnf  = rnf;
        next_status.crc_len   = crc_err;
        next_status.trk0_lost = lost;
        next_status.index_drq = data_request_out;
      end
      CLS_WRITE, CLS_RDADDR: begin
        next_status.seek_rnf  = rnf;
        next_status.crc_len   = crc_err;
        next_status.trk0_lost = lost;
        next_status.index_drq = data_request_out;
      end
      CLS_RDTRACK, CLS_WRTRACK: begin
        next_status.prot_mark = wp;
        next_status.trk0_lost = lost;
        next_status.index_drq = data_request_out;
      end
      CLS_FORMAT: begin
        next_status.prot_mark = wp;
        next_status.crc_len   = ill_len;
        next_status.trk0_lost = lost;
        next_status.index_drq = data_request_out;
      end
      CLS_FORCE: begin
        next_status.prot_mark = wp;
        next_status.trk0_lost = trk0;
        next_status.index_drq = idx;
        next_status.busy      = 1'b0;
      end
      CLS_DELAY: begin
        next_status.busy      = busy;
      end
      default: begin
        next_status.busy      = busy;
      end
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      command_status <= dcsw_status_t'(STATUS_RESET);
    end else begin
      command_status <= next_status;
    end
  end

  // ==========================================================
  // bus read path; other selects belong to other registers
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_DATA    <= STATUS_RESET;
      O_DATA_OE <= 1'b0;
    end else begin
      O_DATA    <= command_status;
      O_DATA_OE <= ~pin.read_strobe_b & (pin.addr == ADDR_STATUS);
    end
  end

  assign O_DATA_REQUEST     = data_request_out;
  // open drain: pull low while no request is pending
  assign O_DATA_REQUEST_OUT = 1'b0;
  assign O_DATA_REQUEST_OE  = ~data_request_out;

  // ==========================================================
  // write gate sequencing
  typedef enum logic [1:0] {
    WG_IDLE, WG_SETUP, WG_WRITE, WG_HOLD
  } dcsw_wg_t;

  dcsw_wg_t         wg_state;
  dcsw_wg_t         next_wg_state;
  logic [CNT_W-1:0] wg_cnt;
  logic [CNT_W-1:0] wg_setup;
  logic [CNT_W-1:0] wg_hold;
  logic             wg_cnt_end;

  assign wg_setup   = I_MFM ? WG_SETUP_MFM_CYC : WG_SETUP_FM_CYC;
  assign wg_hold    = I_MFM ? WG_HOLD_MFM_CYC : WG_HOLD_FM_CYC;
  assign wg_cnt_end = (wg_state == WG_SETUP) ?
                      (wg_cnt >= wg_setup - CNT_W'(1)) :
                      (wg_cnt >= wg_hold - CNT_W'(1));

  always_comb begin
    next_wg_state = wg_state;
    case (wg_state)
      WG_IDLE: begin
        // a medium protected when the request comes never sees the gate open
        if (I_WRITE_REQ && !wp && !mr_active) begin
          next_wg_state = WG_SETUP;
        end
      end
      WG_SETUP: begin
        if (wg_cnt_end) begin
          next_wg_state = WG_WRITE;
        end
      end
      WG_WRITE: begin
        if (!I_WRITE_REQ || mr_active) begin
          next_wg_state = WG_HOLD;
        end
      end
      WG_HOLD: begin
        if (I_WRITE_REQ && !mr_active && !wp) begin
          next_wg_state = WG_WRITE;
        end else if (wg_cnt_end) begin
          next_wg_state = WG_IDLE;
        end
      end
      default: begin
        next_wg_state = WG_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      wg_state <= WG_IDLE;
    end else begin
      wg_state <= next_wg_state;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      wg_cnt <= '0;
    end else if (next_wg_state != wg_state) begin
      wg_cnt <= '0;
    end else if (wg_cnt != '1) begin
      wg_cnt <= wg_cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_WRITE_GATE_OUT  <= 1'b0;
      O_WRITE_PULSE_OUT <= 1'b0;
    end else begin
      O_WRITE_GATE_OUT  <= (next_wg_state != WG_IDLE);
      // pulses pass only once the setup time has run out
      O_WRITE_PULSE_OUT <= (wg_state == WG_WRITE) & I_WRITE_REQ &
                           I_WRITE_PULSE;
    end
  end

endmodule : dcsw_status

`default_nettype wire

//--- tb/dcsw_status_props.sv
// assertion checker for the disk status-word block
`timescale 1ns/1ps
`default_nettype none

module dcsw_status_props (
  input wire logic                 I_CLK,             // clock
  input wire logic                 I_RST_B,           // async reset, low
  input wire dcsw_pkg::dcsw_pins_t I_PINS,            // raw pins
  input wire logic                 I_CMD_START,       // command accepted
  input wire dcsw_pkg::dcsw_cls_t  I_CMD_CLASS,       // command class
  input wire logic                 I_CMD_DONE,        // command finished
  input wire dcsw_pkg::dcsw_evt_t  I_EVENT,           // error events
  input wire logic                 I_BYTE_READY,      // request raise
  input wire logic                 I_HALF_RATE,       // doubled deadline
  input wire logic                 I_MFM,             // double density
  input wire logic [7:0]           O_DATA,            // status word
  input wire logic                 O_DATA_REQUEST,    // request level
  input wire logic                 O_WRITE_GATE_OUT,  // write gate
  input wire logic                 O_WRITE_PULSE_OUT  // write data
);
  import dcsw_pkg::*;
  // ==========================================================
  // helper state
  dcsw_cls_t   cls;
  logic [11:0] req_age;
  logic [11:0] gate_age;
  logic [11:0] wd_age;
  logic        xfer;
  logic        nr;
  assign xfer = cls inside {CLS_READ, CLS_WRITE, CLS_RDADDR, CLS_RDTRACK,
                            CLS_WRTRACK, CLS_FORMAT};
  assign nr = !I_PINS.ready || !I_PINS.master_reset_in_b;
  // a force while busy keeps the running layout
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) cls <= CLS_STEP;
    else if (I_CMD_START && !(I_CMD_CLASS == CLS_FORCE && O_DATA[0]))
      cls <= I_CMD_CLASS;
  end
  // ages saturate so a long idle spell never wraps into a false match
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) req_age <= 12'h000;
    else if (I_BYTE_READY || !O_DATA_REQUEST) req_age <= 12'h000;
    else if (!(&req_age)) req_age <= req_age + 12'h001;
  end
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) gate_age <= 12'h000;
    else if (!O_WRITE_GATE_OUT) gate_age <= 12'h000;
    else if (!(&gate_age)) gate_age <= gate_age + 12'h001;
  end
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) wd_age <= 12'hfff;
    else if (O_WRITE_PULSE_OUT) wd_age <= 12'h000;
    else if (!(&wd_age)) wd_age <= wd_age + 12'h001;
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);

  a_start_preset: assert property (
    I_CMD_START && I_CMD_CLASS != CLS_FORCE
    |-> ##3 (O_DATA[0] && O_DATA[4:3] == 2'h0))
    else $error("status not preset after command start");
  a_busy_done: assert property (
    I_CMD_DONE |-> ##4 !O_DATA[0])
    else $error("busy still set after completion");
  a_not_ready: assert property (
    $stable(nr) [*8] |-> O_DATA[7] == nr)
    else $error("not-ready bit wrong");
  a_crc_flag: assert property (
    I_EVENT.crc_error && cls inside {CLS_STEP, CLS_READ, CLS_WRITE,
    CLS_RDADDR} |-> ##3 O_DATA[3])
    else $error("crc error not flagged");
  a_step_home: assert property (
    (cls == CLS_STEP && !I_PINS.head_at_home_in_b) [*8] |-> O_DATA[2])
    else $error("track zero bit not shown");
  a_drq_mirror: assert property (
    (xfer && $stable(O_DATA_REQUEST)) [*3] |-> O_DATA[1] == O_DATA_REQUEST)
    else $error("request bit differs from request");
  a_lost_data: assert property (
    xfer && (I_HALF_RATE ? req_age == 12'd3390 : req_age == 12'd1700)
    |-> O_DATA[2])
    else $error("unserviced request not flagged lost");
  a_gate_setup: assert property (
    O_WRITE_PULSE_OUT |-> gate_age >= (I_MFM ? 12'd125 : 12'd250))
    else $error("write pulse too soon after gate");
  a_gate_hold: assert property (
    $fell(O_WRITE_GATE_OUT) |-> wd_age >= (I_MFM ? 12'd124 : 12'd249)
    && (!I_MFM || wd_age <= 12'd249))
    else $error("write gate hold out of range");

  c_read: cover property (I_CMD_START && I_CMD_CLASS == CLS_READ);
  c_gate: cover property ($rose(O_WRITE_GATE_OUT));
  c_lost: cover property ($rose(O_DATA[2]));
endmodule : dcsw_status_props

bind dcsw_status dcsw_status_props u_props (.*);
`default_nettype wire

//--- tb/dcsw_host.sv
// host processor model on the strobe bus, servicing data requests
`timescale 1ns/1ps
`default_nettype none

module dcsw_host (
  input  wire logic        i_clk,    // bus clock
  input  wire logic        i_req,    // request pin, pulled up
  input  wire logic        i_oe,     // status bus driven
  input  wire logic [7:0]  i_data,   // status bus
  input  wire logic [11:0] i_delay,  // cycles before servicing
  output logic             o_rd_b,   // read strobe, low active
  output logic             o_wr_b,   // write strobe, low active
  output logic [1:0]       o_addr    // register select
);
  import dcsw_pkg::*;
  logic own = 1'b0;
  initial o_rd_b = 1'b1;
  initial o_wr_b = 1'b1;
  initial o_addr = 2'h1;
  // strobe held past the pin filter; one bus cycle at a time
  task automatic acc(input logic [1:0] a, output logic [7:0] v);
    int n;
    wait (!own);
    own = 1'b1;
    @(posedge i_clk);
    o_addr <= a;
    o_rd_b <= 1'b0;
    v = 8'h00;
    for (n = 0; n < 12; n++) begin
      @(posedge i_clk);
      // an undriven bus reads as unknown, so a missing enable mismatches
      v = i_oe ? i_data : 8'hxx;
      if (n >= 5 && (i_oe || a != ADDR_STATUS)) break;
    end
    o_rd_b <= 1'b1;
    o_addr <= 2'h1;
    repeat (6) @(posedge i_clk);
    own = 1'b0;
  endtask : acc
  // a slow host is only ever asked for through a long delay
  initial forever begin
    logic [7:0] d;
    @(posedge i_clk);
    if (i_req && !own) begin
      repeat (i_delay) @(posedge i_clk);
      acc(ADDR_DATA, d);
    end
  end
endmodule : dcsw_host
`default_nettype wire

//--- tb/dcsw_status_tb.sv
// self-checking bench for the disk status-word block
`timescale 1ns/1ps
`default_nettype none

module dcsw_status_tb;
  import dcsw_pkg::*;
  // ==========================================================
  // stimulus and design
  logic       clk = 0, rst_b = 0, start = 0, done = 0, ext = 0;
  logic       brdy = 0, half = 0, wreq = 0, wpul = 0, mfm = 0;
  logic       ready = 1, wp_b = 1, home_b = 1, idx_b = 1, mr_b = 1;
  logic [5:0] evt = 6'h00;
  logic [11:0] delay = 12'h000;
  dcsw_cls_t  cls = CLS_STEP;
  logic       rd_b, wr_b, oe, data_request_out, drq_out, drq_oe, gate, wdo, req_pin;
  logic [1:0] addr;
  logic [7:0] data;
  int         fail_count = 0, tests_run = 0, cyc = 0, npul = 0;
  dcsw_cls_t  tcls [6] = '{CLS_WRITE, CLS_RDADDR, CLS_RDTRACK,
                           CLS_WRTRACK, CLS_FORMAT, CLS_DELAY};
  logic [7:0] texp [6] = '{8'h19, 8'h19, 8'h41, 8'h41, 8'h49, 8'h01};

  always #4 clk = ~clk;
  assign req_pin = drq_oe ? drq_out : 1'b1;

  dcsw_status dut (.I_CLK(clk), .I_RST_B(rst_b),
    .I_PINS(dcsw_pins_t'({ready, wp_b, home_b, idx_b, mr_b, rd_b, wr_b,
      addr})),
    .I_CMD_START(start), .I_CMD_CLASS(cls), .I_CMD_DONE(done),
    .I_EXT_MODE(ext), .I_EVENT(dcsw_evt_t'(evt)), .I_BYTE_READY(brdy),
    .I_HALF_RATE(half), .I_WRITE_REQ(wreq), .I_WRITE_PULSE(wpul),
    .I_MFM(mfm), .O_DATA(data), .O_DATA_OE(oe), .O_DATA_REQUEST(data_request_out),
    .O_DATA_REQUEST_OUT(drq_out), .O_DATA_REQUEST_OE(drq_oe),
    .O_WRITE_GATE_OUT(gate), .O_WRITE_PULSE_OUT(wdo));

  dcsw_host h (.i_clk(clk), .i_req(req_pin), .i_oe(oe), .i_data(data),
    .i_delay(delay), .o_rd_b(rd_b), .o_wr_b(wr_b), .o_addr(addr));
  // ==========================================================
  // tasks
  task results;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results
  task chk(input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task rchk(input logic [7:0] e);
    logic [7:0] v;
    h.acc(ADDR_STATUS, v);
    chk(e, v);
  endtask : rchk
  task cmd(input dcsw_cls_t c, input logic x);
    @(posedge clk);
    start <= 1'b1;
    cls <= c;
    ext <= x;
    @(posedge clk);
    start <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : cmd
  task fin;
    @(posedge clk);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : fin
  task ev(input logic [5:0] e);
    @(posedge clk);
    evt <= e;
    @(posedge clk);
    evt <= 6'h00;
  endtask : ev
  task pulse_ready;
    @(posedge clk);
    brdy <= 1'b1;
    @(posedge clk);
    brdy <= 1'b0;
  endtask : pulse_ready
  // ==========================================================
  // scenarios
  always @(posedge clk) begin
    cyc++;
    if (wdo) npul++;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (10) @(posedge clk);
    rchk(8'h20);
    ready <= 1'b0;
    rchk(8'ha0);
    ready <= 1'b1;
    mr_b <= 1'b0;
    rchk(8'ha0);
    mr_b <= 1'b1;
    repeat (8) @(posedge clk);
    cmd(CLS_STEP, 1'b0);
    wp_b <= 1'b0;
    home_b <= 1'b0;
    idx_b <= 1'b0;
    rchk(8'h67);
    ev(6'h30);
    rchk(8'h7f);
    fin();
    rchk(8'h7e);
    home_b <= 1'b1;
    idx_b <= 1'b1;
    for (int x = 0; x < 2; x++) begin
      cmd(CLS_READ, x[0]);
      rchk(8'h01);
      ev(6'h1e);
      rchk({1'b0, x[0], 6'h39});
      fin();
    end
    for (int i = 0; i < 6; i++) begin
      cmd(tcls[i], 1'b1);
      ev(6'h3f);
      rchk(texp[i]);
      fin();
    end
    cmd(CLS_READ, 1'b0);
    cmd(CLS_FORCE, 1'b0);
    rchk(8'h00);
    home_b <= 1'b0;
    idx_b <= 1'b0;
    cmd(CLS_FORCE, 1'b0);
    rchk(8'h46);
    wp_b <= 1'b1;
    home_b <= 1'b1;
    idx_b <= 1'b1;
    cmd(CLS_READ, 1'b0);
    pulse_ready();
    @(posedge clk);
    chk(8'h01, {7'h00, data_request_out});
    chk(8'h01, {7'h00, req_pin});
    repeat (30) @(posedge clk);
    rchk(8'h01);
    delay <= 12'd1800;
    pulse_ready();
    repeat (20) @(posedge clk);
    rchk(8'h03);
    repeat (1800) @(posedge clk);
    rchk(8'h05);
    half <= 1'b1;
    delay <= 12'd2500;
    cmd(CLS_READ, 1'b0);
    pulse_ready();
    repeat (2600) @(posedge clk);
    rchk(8'h01);
    half <= 1'b0;
    delay <= 12'h000;
    fin();
    for (int m = 0; m < 2; m++) begin
      int n;
      @(posedge clk);
      npul = 0;
      mfm <= m[0];
      wreq <= 1'b1;
      repeat (2) @(posedge clk);
      chk(8'h01, {7'h00, gate});
      repeat (300) begin
        @(posedge clk);
        wpul <= 1'b1;
        @(posedge clk);
        wpul <= 1'b0;
      end
      wreq <= 1'b0;
      for (n = 0; n < 400 && gate; n++) @(posedge clk);
      chk(8'h01, {7'h00, n > int'(m ? WG_HOLD_MFM_CYC : WG_HOLD_FM_CYC) &&
        (m == 0 || n <= 251)});
      // pulses offered before the setup time has run out are dropped
      chk(8'(300 - (int'(m ? WG_SETUP_MFM_CYC : WG_SETUP_FM_CYC) - 1) / 2),
        8'(npul));
    end
    results();
  end
endmodule : dcsw_status_tb
`default_nettype wire
